// >>> hw/sync_serial_pkg.sv
// Constants, state enumeration and state record of the buffered serial port.
// Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
package sync_serial_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] BUF_IDX_FIRST = 14'h0fa0; // First buffer word
  localparam logic [13:0] BUF_IDX_LAST = 14'h0fa7;  // Last buffer word
  localparam logic [13:0] CTRL1_IDX = 14'h0fa8;     // Control one, write only
  localparam logic [13:0] CTRL2_IDX = 14'h0fa9;     // Control two on write, status on read
  localparam logic [13:0] MISC_IDX = 14'h0faa;      // Divider source select

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int RUN_BIT = 7;         // transfer_run
  localparam int ABORT_BIT = 6;       // abort_request
  localparam int MODE_LSB = 3;        // transfer_mode_select [5:3]
  localparam int CLK_LSB = 0;         // clock_source_select [2:0]
  localparam int WAIT_LSB = 3;        // frame_wait_select [4:3]
  localparam int COUNT_LSB = 0;       // word_count_field [2:0]
  localparam int STAT_ACTIVE_BIT = 7; // transfer_active_flag
  localparam int STAT_SHIFT_BIT = 6;  // shift_active_flag
  localparam int DIVSEL_BIT = 0;      // divider_source_select
  localparam logic [2:0] MODE_RST = 3'h0;  // Mode after reset
  localparam logic [2:0] CLK_RST = 3'h0;   // Clock source after reset

  // ----------------------------------------------------------------
  // Mode and clock source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_TX8 = 3'h0;  // 8-bit transmit
  localparam logic [2:0] MODE_TX4 = 3'h2;  // 4-bit transmit
  localparam logic [2:0] MODE_TRX8 = 3'h4; // 8-bit full duplex
  localparam logic [2:0] MODE_RX8 = 3'h5;  // 8-bit receive
  localparam logic [2:0] MODE_RX4 = 3'h6;  // 4-bit receive
  localparam logic [2:0] CLK_SLOWEST = 3'h0;  // Divide by 2^13 or low-frequency/2^5
  localparam logic [2:0] CLK_RESERVED = 3'h6; // Reserved code
  localparam logic [2:0] CLK_EXTERNAL = 3'h7; // Clock from the pin

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [3:0] DIV_EXP_SLOW = 4'd13;   // Exponent of code 000
  localparam logic [3:0] DIV_EXP_BASE = 4'd9;    // Exponent is this minus the code
  localparam logic [4:0] LF_HALF_MASK = 5'h0f;   // Half period of low-frequency/2^5
  localparam logic [6:0] HALF_TICKS_WORD = 7'd16; // Half periods in one 8-bit word

  localparam logic [1:0] RESP_OKAY = 2'b00;   // AXI OKAY
  localparam logic [1:0] RESP_SLVERR = 2'b10; // AXI SLVERR

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP, ST_HOLD} eng_state_t;

  typedef struct packed {
    logic awv;                // Write address held
    logic [15:0] awaddr;      // Held write address
    logic wv;                 // Write data held
    logic [7:0] wdata;        // Held write data, low byte
    logic wstrb0;             // Held strobe of the low byte
    logic bvalid;             // Write response pending
    logic [1:0] bresp;        // Write response code
    logic rvalid;             // Read data pending
    logic [31:0] rdata;       // Read data
    logic [1:0] rresp;        // Read response code
    logic run;                // transfer_run
    logic abort;              // abort_request, self clearing
    logic [2:0] mode;         // transfer_mode_select
    logic [2:0] clksrc;       // clock_source_select
    logic [1:0] wsel;         // frame_wait_select
    logic [2:0] wcnt;         // word_count_field
    logic lfsel;              // divider_source_select
    logic [7:0][7:0] buffer;  // data_buffer_words
    eng_state_t st;           // Engine state
    logic [2:0] idx;          // Current buffer word
    logic [2:0] bitc;         // Bits done in current word
    logic [7:0] sh;           // Shift register
    logic sclk;               // Internal serial clock level
    logic so;                 // serial_data_out level
    logic active;             // transfer_active_flag
    logic stop_pend;          // Stop at end of word
    logic irq;                // serial_done_irq pulse
    logic svc;                // Buffer serviced since block start
    logic [12:0] div;         // System clock divider
    logic [4:0] lfdiv;        // Low-frequency divider
    logic [6:0] gap;          // Frame wait half periods left
    logic sck_s1;             // Pin synchroniser, first stage
    logic sck_s2;             // Pin synchroniser, second stage
    logic sck_s3;             // Edge detect stage
  } sio_state_t;

endpackage

// >>> hw/sync_serial_buffered_port.sv
// Buffered synchronous serial port with an AXI4-Lite register slave.
// Assumes all inputs are synchronous to clk_sys_i except serial_clock_pin_i.
`timescale 1ns/1ps

module sync_serial_buffered_port
  import sync_serial_pkg::*;
(
  input wire logic clk_sys_i,            // System clock, 100 MHz
  input wire logic resetn_i,             // Asynchronous reset, active low
  input wire logic [15:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i,      // Write address valid
  output logic s_axi_awready_o,          // Write address ready
  input wire logic [31:0] s_axi_wdata_i, // Write data
  input wire logic [3:0] s_axi_wstrb_i,  // Write strobes
  input wire logic s_axi_wvalid_i,       // Write data valid
  output logic s_axi_wready_o,           // Write data ready
  output logic [1:0] s_axi_bresp_o,      // Write response
  output logic s_axi_bvalid_o,           // Write response valid
  input wire logic s_axi_bready_i,       // Write response ready
  input wire logic [15:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i,      // Read address valid
  output logic s_axi_arready_o,          // Read address ready
  output logic [31:0] s_axi_rdata_o,     // Read data
  output logic [1:0] s_axi_rresp_o,      // Read response
  output logic s_axi_rvalid_o,           // Read data valid
  input wire logic s_axi_rready_i,       // Read data ready
  input wire logic low_freq_tick_i,      // One pulse per low-frequency clock period
  input wire logic serial_clock_pin_i,   // Serial clock pin level
  output logic serial_clock_pin_o,       // Serial clock driven out
  output logic serial_clock_pin_oe_n_o,  // Low while the clock pin is driven
  input wire logic serial_data_in_i,     // Serial data in
  output logic serial_data_out_o,        // serial_data_out
  output logic serial_done_irq_o         // serial_done_irq, one-cycle pulse
);

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  sio_state_t s_q; // Registered state
  sio_state_t s_d; // Next state

  logic wr_go;        // Write address and data both held
  logic rd_go;        // Read address accepted
  logic [13:0] widx;  // Write register index
  logic [13:0] ridx;  // Read register index
  logic buf_wr;       // Buffer word written
  logic buf_rd;       // Buffer word read
  logic wr_hit;       // Write to a mapped register
  logic rd_hit;       // Read of a mapped register
  logic ctrl_wr;      // Control one written
  logic tx_en;        // Mode transmits
  logic rx_en;        // Mode receives
  logic is4;          // 4-bit mode
  logic internal;     // Internal serial clock
  logic svc_now;      // Access that services the buffer
  logic [3:0] div_exp; // Divider exponent
  logic [12:0] half_mask; // Divider half period mask
  logic half_tick;    // Internal clock half period elapsed
  logic lead;         // Leading (falling) serial clock edge
  logic trail;        // Trailing (rising) serial clock edge
  logic word_done;    // Last bit of a word sampled
  logic last_word;    // Current word is the last of the block
  logic frame_wait;   // Gap after each word applies
  logic [6:0] gap_len; // Gap length in half periods
  logic [7:0] sh_shift; // Shift register after a sample
  logic [7:0] rx_word;  // Received word as stored
  logic [7:0] load;     // Shift register content at leading edge

  // Legal codes of transfer_mode_select
  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = (m == MODE_TX8) || (m == MODE_TX4) || (m == MODE_TRX8) ||
                 (m == MODE_RX8) || (m == MODE_RX4);
  endfunction

  assign widx = s_q.awaddr[15:2];
  assign ridx = s_axi_araddr_i[15:2];
  assign wr_go = s_q.awv && s_q.wv && !s_q.bvalid;
  assign rd_go = s_axi_arvalid_i && !s_q.rvalid;
  assign wr_hit = (widx >= BUF_IDX_FIRST && widx <= MISC_IDX);
  assign rd_hit = (ridx >= BUF_IDX_FIRST && ridx <= MISC_IDX);
  assign buf_wr = wr_go && s_q.wstrb0 && widx >= BUF_IDX_FIRST && widx <= BUF_IDX_LAST;
  assign buf_rd = rd_go && ridx >= BUF_IDX_FIRST && ridx <= BUF_IDX_LAST;
  assign ctrl_wr = wr_go && s_q.wstrb0 && widx == CTRL1_IDX;

  // Mode decode
  assign tx_en = (s_q.mode == MODE_TX8) || (s_q.mode == MODE_TX4) ||
                 (s_q.mode == MODE_TRX8);
  assign rx_en = (s_q.mode == MODE_TRX8) || (s_q.mode == MODE_RX8) ||
                 (s_q.mode == MODE_RX4);
  assign is4 = (s_q.mode == MODE_TX4) || (s_q.mode == MODE_RX4);
  assign internal = (s_q.clksrc != CLK_EXTERNAL);
  // Duplex and transmit release on a write, receive on a read
  assign svc_now = tx_en ? buf_wr : buf_rd;

  // ----------------------------------------------------------------
  // Serial clock generation and edge detection
  // ----------------------------------------------------------------
  assign div_exp = (s_q.clksrc == CLK_SLOWEST) ? DIV_EXP_SLOW :
                   DIV_EXP_BASE - {1'b0, s_q.clksrc};
  assign half_mask = (13'h0001 << (div_exp - 4'd1)) - 13'h0001;
  assign half_tick = (s_q.clksrc == CLK_SLOWEST && s_q.lfsel) ?
                     (low_freq_tick_i && (s_q.lfdiv & LF_HALF_MASK) == LF_HALF_MASK) :
                     ((s_q.div & half_mask) == half_mask);
  assign lead = (s_q.st == ST_SHIFT) &&
                (internal ? (s_q.sclk && half_tick) : (s_q.sck_s3 && !s_q.sck_s2));
  assign trail = (s_q.st == ST_SHIFT) &&
                 (internal ? (!s_q.sclk && half_tick) : (!s_q.sck_s3 && s_q.sck_s2));
  assign word_done = trail && (s_q.bitc == (is4 ? 3'd3 : 3'd7));
  assign last_word = (s_q.idx == s_q.wcnt);
  assign frame_wait = internal && (s_q.wsel != 2'b00) &&
                      (s_q.mode == MODE_TRX8 || s_q.mode == MODE_RX8);
  assign gap_len = ((7'h01 << s_q.wsel) - 7'h01) * HALF_TICKS_WORD;
  assign sh_shift = {serial_data_in_i, s_q.sh[7:1]};
  assign rx_word = is4 ? {4'h0, sh_shift[7:4]} : sh_shift;
  assign load = (s_q.bitc == 3'd0) ? s_q.buffer[s_q.idx] : s_q.sh;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.abort = 1'b0;
    s_d.sck_s1 = serial_clock_pin_i;
    s_d.sck_s2 = s_q.sck_s1;
    s_d.sck_s3 = s_q.sck_s2;
    s_d.div = s_q.div + 13'd1;
    if (low_freq_tick_i)
    begin
      s_d.lfdiv = s_q.lfdiv + 5'd1;
    end
    // Bus channels, one write and one read at a time
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      s_d.awv = 1'b1;
      s_d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      s_d.wv = 1'b1;
      s_d.wdata = s_axi_wdata_i[7:0];
      s_d.wstrb0 = s_axi_wstrb_i[0];
    end
    if (s_q.bvalid && s_axi_bready_i)
    begin
      s_d.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      s_d.awv = 1'b0;
      s_d.wv = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready_i)
    begin
      s_d.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata = 32'h0000_0000;
      if (ridx <= BUF_IDX_LAST && ridx >= BUF_IDX_FIRST)
      begin
        s_d.rdata[7:0] = s_q.buffer[ridx[2:0]];
      end
      else if (ridx == CTRL2_IDX)
      begin
        s_d.rdata[STAT_ACTIVE_BIT] = s_q.active;
        s_d.rdata[STAT_SHIFT_BIT] = (s_q.st == ST_SHIFT);
      end
      else if (ridx == MISC_IDX)
      begin
        s_d.rdata[DIVSEL_BIT] = s_q.lfsel;
      end
    end
    // Buffer serviced since the block started
    if (svc_now)
    begin
      s_d.svc = 1'b1;
    end
    // Serial engine
    unique case (s_q.st)
      ST_IDLE:
      begin
        s_d.sclk = 1'b1;
      end
      ST_SHIFT:
      begin
        // Leading edge: load word at its first bit and drive the LSB, or high in the receive-only modes
        if (lead)
        begin
          s_d.sh = load;
          s_d.so = tx_en ? load[0] : 1'b1;
          s_d.sclk = 1'b0;
        end
        // Trailing edge: sample into the top of the shift register
        if (trail)
        begin
          s_d.sh = sh_shift;
          s_d.bitc = s_q.bitc + 3'd1;
          s_d.sclk = 1'b1;
        end
        if (word_done)
        begin
          s_d.bitc = 3'd0;
          if (rx_en)
          begin
            s_d.buffer[s_q.idx] = rx_word;
          end
          if (s_q.stop_pend)
          begin
            s_d.st = ST_IDLE;
            s_d.active = 1'b0;
            s_d.stop_pend = 1'b0;
          end
          else
          begin
            s_d.idx = last_word ? 3'd0 : s_q.idx + 3'd1;
            s_d.irq = last_word;
            if (last_word && internal && !s_q.svc && !svc_now)
            begin
              s_d.st = ST_HOLD;
            end
            else
            begin
              if (last_word)
              begin
                s_d.svc = 1'b0;
              end
              if (frame_wait)
              begin
                s_d.st = ST_GAP;
                s_d.gap = gap_len - 7'd1;
              end
            end
          end
        end
      end
      ST_GAP:
      begin
        // Idle interval between words, clock held high
        if (s_q.stop_pend)
        begin
          s_d.st = ST_IDLE;
          s_d.active = 1'b0;
          s_d.stop_pend = 1'b0;
        end
        else if (half_tick)
        begin
          if (s_q.gap == 7'd0)
          begin
            s_d.st = ST_SHIFT;
          end
          else
          begin
            s_d.gap = s_q.gap - 7'd1;
          end
        end
      end
      ST_HOLD:
      begin
        // Automatic wait until the buffer is serviced
        if (s_q.stop_pend)
        begin
          s_d.st = ST_IDLE;
          s_d.active = 1'b0;
          s_d.stop_pend = 1'b0;
        end
        else if (svc_now || s_q.svc)
        begin
          s_d.st = frame_wait ? ST_GAP : ST_SHIFT;
          s_d.gap = gap_len - 7'd1;
          s_d.svc = 1'b0;
        end
      end
    endcase
    // Register writes; these take precedence over the engine
    if (buf_wr)
    begin
      s_d.buffer[widx[2:0]] = s_q.wdata;
    end
    if (wr_go && s_q.wstrb0 && widx == CTRL2_IDX)
    begin
      s_d.wsel = s_q.wdata[WAIT_LSB +: 2];
      s_d.wcnt = s_q.wdata[COUNT_LSB +: 3];
    end
    if (wr_go && s_q.wstrb0 && widx == MISC_IDX)
    begin
      s_d.lfsel = s_q.wdata[DIVSEL_BIT];
    end
    if (ctrl_wr)
    begin
      s_d.mode = s_q.wdata[MODE_LSB +: 3];
      s_d.clksrc = s_q.wdata[CLK_LSB +: 3];
      s_d.run = s_q.wdata[RUN_BIT];
      if (s_q.wdata[MODE_LSB +: 3] != s_q.mode)
      begin
        s_d.buffer = '0;
      end
      if (s_q.wdata[ABORT_BIT])
      begin
        // Abort: stop at once, word in progress is dropped
        s_d.abort = 1'b1;
        s_d.st = ST_IDLE;
        s_d.active = 1'b0;
        s_d.stop_pend = 1'b0;
        s_d.sclk = 1'b1;
      end
      else if (s_q.wdata[RUN_BIT])
      begin
        s_d.stop_pend = 1'b0;
        if (!s_q.active && mode_legal(s_q.wdata[MODE_LSB +: 3]) &&
            s_q.wdata[CLK_LSB +: 3] != CLK_RESERVED)
        begin
          s_d.active = 1'b1;
          s_d.st = ST_SHIFT;
          s_d.idx = 3'd0;
          s_d.bitc = 3'd0;
          s_d.svc = 1'b0;
          s_d.sclk = 1'b1;
        end
      end
      else if (s_q.active)
      begin
        // Stop: finish the word in progress, else end now
        if (s_q.st == ST_SHIFT)
        begin
          s_d.stop_pend = 1'b1;
        end
        else
        begin
          s_d.st = ST_IDLE;
          s_d.active = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_q <= '0;
      s_q.mode <= MODE_RST;
      s_q.clksrc <= CLK_RST;
      s_q.sclk <= 1'b1;
      s_q.so <= 1'b1;
      s_q.sck_s1 <= 1'b1;
      s_q.sck_s2 <= 1'b1;
      s_q.sck_s3 <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready_o = !s_q.awv && !s_q.bvalid;
  assign s_axi_wready_o = !s_q.wv && !s_q.bvalid;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_arready_o = !s_q.rvalid;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;
  assign serial_clock_pin_o = s_q.sclk;
  assign serial_clock_pin_oe_n_o = !internal;
  assign serial_data_out_o = s_q.so;
  assign serial_done_irq_o = s_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_block_end;
    word_done && last_word && internal && !s_q.stop_pend && !s_q.svc && !svc_now && !ctrl_wr;
  endsequence
  sequence s_waiting;
    (s_q.st == ST_HOLD) && !svc_now && !s_q.stop_pend && !ctrl_wr;
  endsequence

  property p_irq_count;
    serial_done_irq_o |-> $past(word_done) && $past(s_q.idx) == $past(s_q.wcnt);
  endproperty
  a_irq_count: assert property (p_irq_count) else $error("irq without full block");

  property p_run_active;
    ctrl_wr && s_q.wdata[RUN_BIT] && !s_q.wdata[ABORT_BIT] && !s_q.active &&
    mode_legal(s_q.wdata[MODE_LSB +: 3]) && s_q.wdata[CLK_LSB +: 3] != CLK_RESERVED
    |=> s_q.active && s_q.st == ST_SHIFT && s_q.idx == 3'd0;
  endproperty
  a_run_active: assert property (p_run_active) else $error("start did not set active");

  property p_abort;
    ctrl_wr && s_q.wdata[ABORT_BIT] |=> !s_q.active && s_q.abort ##1 !s_q.abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not immediate or sticky");

  property p_done_clear;
    $fell(s_q.active) |-> $past(word_done && s_q.stop_pend) ||
      $past(ctrl_wr) || $past(s_q.stop_pend && s_q.st != ST_SHIFT);
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("active cleared unexpectedly");

  property p_rx_store;
    word_done && rx_en && !buf_wr && !ctrl_wr |=>
      s_q.buffer[$past(s_q.idx)] == $past(rx_word);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("received word not stored");

  property p_lead;
    $changed(serial_data_out_o) |-> $past(lead);
  endproperty
  a_lead: assert property (p_lead) else $error("data out changed off leading edge");

  property p_hold;
    s_block_end |=> s_waiting [*1] or (s_q.st == ST_HOLD);
  endproperty
  a_hold: assert property (p_hold) else $error("no automatic wait after block");

  property p_hold_stay;
    s_waiting |=> s_q.st == ST_HOLD && serial_clock_pin_o;
  endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("wait released unserviced");

  property p_stop_finish;
    s_q.stop_pend && s_q.st == ST_SHIFT && !word_done && !ctrl_wr |=> s_q.active;
  endproperty
  a_stop_finish: assert property (p_stop_finish) else $error("stop cut word short");

endmodule

// >>> verif/serial_peer_model.sv
// Far-side serial peripheral: shifts one byte each way, LSB first.
// Assumes its serial clock idles high, from the port or from the bench.
`timescale 1ns/1ps
module serial_peer_model (
  input wire logic sclk_i,       // Serial clock, from the port or from the bench
  input wire logic sdo_i,        // Data from the port
  input wire logic [7:0] tx_i,   // Byte to send
  output logic sdi_o,            // Data to the port
  output logic [7:0] rx_o        // Byte received
);
  logic [2:0] cnt_q = 3'h0; // Bit position
  logic armed_q = 1'b0;     // Set by the first real falling edge
  initial sdi_o = 1'b0;
  initial rx_o = 8'h00;
  // Drive on the leading edge
  always @(negedge sclk_i)
  begin
    sdi_o <= tx_i[cnt_q];
    armed_q <= 1'b1;
  end
  // Sample on the trailing edge; the unknown-to-high step at reset is no edge
  always @(posedge sclk_i)
  begin
    if (armed_q)
    begin
      rx_o <= {sdo_i, rx_o[7:1]};
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench of the buffered serial port over AXI4-Lite.
// Assumes a 100 MHz clock and the peer model on the serial pins.
`timescale 1ns/1ps
module tb_top;
  import sync_serial_pkg::*;
  logic clk_sys = 0, resetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, xck = 1;
  logic [15:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, v;
  logic [1:0] bresp, rresp, r;
  logic awr, wrdy, bv, arr, rv, sclk, oen, sdo, sdi, irq;
  wire pck = oen ? xck : sclk; // Peer clock: the port's own, or the bench's when external
  logic [7:0] prx;
  int fails = 0, num_checks = 0, n;
  logic [15:0] ra [4] = '{16'h3e80, 16'h3e9c, 16'h3ea0, 16'h0000}; // Row addresses
  logic [31:0] rw [4] = '{32'ha5, 32'h5a, 32'h0, 32'h77};         // Written
  logic [31:0] re [4] = '{32'ha5, 32'h5a, 32'h0, 32'h0};          // Read back
  logic [1:0] rr [4] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
  always #5 clk_sys = ~clk_sys;
  sync_serial_buffered_port sync_serial_buffered_port_i (.clk_sys_i(clk_sys),
    .resetn_i(resetn), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .low_freq_tick_i(1'b0), .serial_clock_pin_i(xck), .serial_clock_pin_o(sclk),
    .serial_clock_pin_oe_n_o(oen), .serial_data_in_i(sdi), .serial_data_out_o(sdo),
    .serial_done_irq_o(irq));
  serial_peer_model serial_peer_model_i (.sclk_i(pck), .sdo_i(sdo), .tx_i(8'hc3),
    .sdi_o(sdi), .rx_o(prx));
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] rs);
    logic ta, tw;
    ta = 0; tw = 0; n = 0;
    @(posedge clk_sys);
    awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; bry <= 1;
    while (!(bv && ta && tw))
    begin
      @(posedge clk_sys);
      if (awr && !ta) begin ta = 1; awv <= 0; end
      if (wrdy && !tw) begin tw = 1; wv <= 0; end
      if (++n > 500) begin fails++; end_of_test(); end
    end
    rs = bresp; bry <= 0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk_sys);
    ara <= a; arv <= 1; rry <= 1; n = 0;
    do
    begin
      @(posedge clk_sys);
      if (arr && arv) arv <= 0;
      if (++n > 500) begin fails++; end_of_test(); end
    end while (!rv);
    d = rdat; rs = rresp; rry <= 0;
  endtask
  // External serial clock: k pulses of 8 low and 8 high system clocks
  task automatic xpulse(input int k);
    repeat (k)
    begin
      xck <= 0;
      repeat (8) @(posedge clk_sys);
      xck <= 1;
      repeat (8) @(posedge clk_sys);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    chk({sdo, sclk, irq, oen}, 32'h0c);
    resetn <= 1;
    for (int i = 0; i < 4; i++)
    begin
      wr(ra[i], rw[i][7:0], r); chk(r, rr[i]);
      rd(ra[i], v, r); chk(v, re[i]); chk(r, rr[i]);
    end
    wr(16'h3ea0, 8'h65, r);
    wr(16'h3e80, 8'h3c, r);
    wr(16'h3ea4, 8'h00, r);
    wr(16'h3ea0, 8'ha5, r);
    rd(16'h3ea4, v, r); chk(v[7], 1);
    n = 0;
    while (!irq && n < 3000) begin @(posedge clk_sys); n++; end
    chk(irq, 1);
    wr(16'h3ea4, 8'h00, r);
    repeat (60) @(posedge clk_sys);
    chk({sclk, prx}, 32'h13c);
    rd(16'h3e80, v, r); chk(v, 32'hc3);
    rd(16'h3ea4, v, r); chk(v[7], 1);
    // Refill releases the wait; a stop then lets the word finish
    wr(16'h3e80, 8'h81, r);
    rd(16'h3ea4, v, r); chk(v[7:6], 2'h3);
    wr(16'h3ea0, 8'h25, r);
    rd(16'h3ea4, v, r); chk(v[7], 1);
    repeat (200) @(posedge clk_sys);
    chk({sclk, prx}, 32'h181);
    rd(16'h3ea4, v, r); chk(v[7:6], 2'h0);
    rd(16'h3e80, v, r); chk(v, 32'hc3);
    // External clock from the bench
    wr(16'h3ea0, 8'h67, r); chk(oen, 1);
    wr(16'h3e80, 8'h5a, r);
    wr(16'h3ea0, 8'ha7, r);
    xpulse(8);
    chk(prx, 32'h5a);
    rd(16'h3e80, v, r); chk(v, 32'hc3);
    wr(16'h3e80, 8'h96, r);
    wr(16'h3ea0, 8'h27, r);
    xpulse(8);
    rd(16'h3ea4, v, r); chk(v[7], 0);
    chk(prx, 32'h96);
    wr(16'h3ea4, 8'h00, r);
    // Abort in mid-word, then a mode change
    wr(16'h3ea0, 8'h65, r);
    wr(16'h3ea0, 8'ha5, r);
    wr(16'h3ea0, 8'h65, r);
    rd(16'h3ea4, v, r); chk(v[7:6], 2'h0);
    wr(16'h3ea0, 8'h6d, r);
    rd(16'h3e80, v, r); chk(v, 32'h0);
    end_of_test();
  end
endmodule
